//--- pkg/htf_params.svh
// constants of the humidity/temperature sensor host controller
// assumes a 100 MHz system clock; the host makes the bus clock itself
`ifndef HTF_PARAMS_SVH
`define HTF_PARAMS_SVH
`define HTF_DEV_ADDR      7'h44
`define HTF_CMD_ENTER     8'ha0
`define HTF_CMD_EXIT      8'h80
`define HTF_CMD_ZERO      8'h00
`define HTF_NV_HUM_RD     8'h06
`define HTF_NV_TMP_RD     8'h11
`define HTF_NV_HUM_WR     8'h46
`define HTF_NV_TMP_WR     8'h51
`define HTF_NV_ID_HI      8'h1e
`define HTF_NV_ID_LO      8'h1f
`define HTF_RES_MSB       11
`define HTF_RES_LSB       10
`define HTF_RES_DEFAULT   2'h3
`define HTF_STAT_VALID    2'h0
`define HTF_STAT_STALE    2'h1
`define HTF_NV_RD_BYTES   3'h3
`define HTF_WB_CTRL       8'h00
`define HTF_WB_STAT       8'h04
`define HTF_WB_HUM        8'h08
`define HTF_WB_TEMP       8'h0c
`define HTF_WB_NVDATA     8'h10
`define HTF_WB_NVADDR     8'h14
`define HTF_WB_RES        8'h18
`define HTF_CLK_NS        10
`define HTF_SCL_NS        10000
`define HTF_QTR_CYC       8'((`HTF_SCL_NS / `HTF_CLK_NS) / 4)
`define HTF_LOAD_NS       120000
`define HTF_LOAD_CYC      ((`HTF_LOAD_NS + `HTF_CLK_NS - 1) / `HTF_CLK_NS)
`define HTF_COMMIT_NS     14000000
`define HTF_COMMIT_CYC    ((`HTF_COMMIT_NS + `HTF_CLK_NS - 1) / `HTF_CLK_NS)
`define HTF_MEAS_NS       33900000
`define HTF_MEAS_CYC      ((`HTF_MEAS_NS + `HTF_CLK_NS - 1) / `HTF_CLK_NS)
`endif

//--- pkg/htf_pkg.sv
// types of the humidity/temperature sensor host controller
// assumes nothing beyond the params header
package htf_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_BIT   = 3'b010,
    ST_STOP  = 3'b011,
    ST_WAIT  = 3'b100
  } htf_state_t;
  typedef enum logic [2:0] {
    OP_NONE    = 3'b000,
    OP_MEASURE = 3'b001,
    OP_FETCH   = 3'b010,
    OP_ENTER   = 3'b011,
    OP_EXIT    = 3'b100,
    OP_NVREAD  = 3'b101,
    OP_NVWRITE = 3'b110,
    OP_RESOLVE = 3'b111
  } htf_op_t;
endpackage

//--- verification/htf_sensor_model.sv
// behavioural sensor on the far side of the two-wire link
// assumes the bench resolves both open-drain wires with pull-ups
module htf_sensor_model #(
  parameter logic [6:0]  DEV_ADDR  = 7'h44,
  parameter logic [13:0] HUM_VAL   = 14'h1a5c,
  parameter logic [13:0] TMP_VAL   = 14'h2b3d,
  parameter logic [15:0] HUM_WORD  = 16'h4c21,
  parameter logic [15:0] TMP_WORD  = 16'h8d37,
  parameter logic [15:0] ID_HI     = 16'h1234, // arbitrary value
  parameter logic [15:0] ID_LO     = 16'h5678, // arbitrary value
  parameter int          MEAS_NS   = 300,
  parameter int          LOAD_NS   = 250,
  parameter int          COMMIT_NS = 400
) (
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic mute_i,
  input  wire logic slow_i,
  output logic      scl_dn_o,
  output logic      sda_dn_o,
  output logic      viol_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] hum_nv, tmp_nv, rd_word;
  logic [13:0] hum_r, tmp_r;
  logic        stale_r, prog_r, stop, ack, hit;
  logic [7:0]  b [0:3];
  logic [7:0]  a;
  int          n;
  time         t_ready;

  task automatic rx(output logic [7:0] v, input logic first);
    for (int i = 7; i >= 0; i--) begin
      @(posedge scl_i);
      v[i] = sda_i;
      @(negedge scl_i or posedge sda_i);
      if (scl_i) begin
        stop = 1;
        return;
      end
    end
    if (first) hit = (v[7:1] == DEV_ADDR) && !mute_i;
    sda_dn_o = hit;
    @(posedge scl_i);
    @(negedge scl_i);
    sda_dn_o = 0;
    // slow answer: hold the clock wire low a while
    if (slow_i) begin
      scl_dn_o = 1;
      #2000 scl_dn_o = 0;
    end
  endtask

  task automatic tx(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      sda_dn_o = !v[i];
      @(posedge scl_i);
      @(negedge scl_i);
    end
    sda_dn_o = 0;
    @(posedge scl_i);
    ack = !sda_i;
    @(negedge scl_i);
  endtask

  task automatic measure;
    #MEAS_NS;
    hum_r = HUM_VAL;
    tmp_r = TMP_VAL;
    stale_r = 0;
  endtask

  task automatic command;
    if (b[0] == 8'ha0 && {b[1], b[2]} == 16'h0 && $time < 64'd10000000) begin
      prog_r = 1;
      t_ready = $time + LOAD_NS;
    end else if (b[0] == 8'h80 && {b[1], b[2]} == 16'h0) begin
      prog_r = 0;
    end else if (prog_r) begin
      case (b[0])
        8'h06: rd_word = hum_nv;
        8'h11: rd_word = tmp_nv;
        8'h1e: rd_word = ID_HI;
        8'h1f: rd_word = ID_LO;
        8'h46: hum_nv = {b[1], b[2]};
        8'h51: tmp_nv = {b[1], b[2]};
        default: ;
      endcase
      t_ready = $time + ((b[0] == 8'h46 || b[0] == 8'h51) ? COMMIT_NS : LOAD_NS);
    end
  endtask

  initial begin
    {scl_dn_o, sda_dn_o, viol_o, prog_r, hit} = '0;
    stale_r = 1;
    {hum_r, tmp_r} = '1;
    {hum_nv, tmp_nv, rd_word} = {HUM_WORD, TMP_WORD, 16'h0};
    t_ready = 0;
    forever begin
      @(negedge sda_i iff scl_i === 1'b1);
      if (prog_r && $time < t_ready) viol_o = 1;
      stop = 0;
      n = 0;
      rx(a, 1);
      if (!stop && hit && a[0]) begin
        if (prog_r) {b[0], b[1], b[2]} = {8'h81, rd_word};
        else begin
          {b[0], b[1]} = {(stale_r ? 2'b01 : 2'b00), hum_r};
          {b[2], b[3]} = {tmp_r, 2'b11};
        end
        ack = 1;
        while (ack && n < 4) begin
          tx(b[n]);
          n++;
        end
        if (!prog_r) stale_r = 1;
      end else if (!stop && hit) begin
        while (!stop && n < 4) begin
          rx(b[n], 0);
          if (!stop) n++;
        end
        if (n == 0 && !prog_r) fork measure(); join_none
        else if (n == 3) command();
      end
    end
  end
endmodule // htf_sensor_model

//--- verification/test_htf_host.sv
// self-checking bench for the sensor host controller
// assumes the behavioural sensor model and pull-ups on both wires
`include "htf_params.svh"
module test_htf_host;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [13:0] HUM_VAL  = 14'h1a5c;
  localparam logic [13:0] TMP_VAL  = 14'h2b3d;
  localparam logic [15:0] HUM_WORD = 16'h4c21;
  localparam logic [15:0] TMP_WORD = 16'h8d37;
  localparam logic [15:0] ID_HI    = 16'h1234; // arbitrary value
  localparam logic [15:0] ID_LO    = 16'h5678; // arbitrary value
  logic        clk_i, rst_i, cyc, stb, we, mute, slow, ack_o;
  logic        scl_o, scl_oe_n, sda_o, sda_oe_n, scl_dn, sda_dn, viol;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat_o, q;
  logic [7:0]  nv_adr [0:3];
  logic [15:0] nv_exp [0:3];
  int          n_fail, check_count;
  wire         scl_w = !((scl_oe_n === 1'b0 && scl_o !== 1'b1) || scl_dn === 1'b1);
  wire         sda_w = !((sda_oe_n === 1'b0 && sda_o !== 1'b1) || sda_dn === 1'b1);

  // short quarters keep the whole run far below the cycle budget
  htf_host #(.LOAD_CYC(32'd20), .COMMIT_CYC(32'd40), .MEAS_CYC(32'd40), .QTR_CYC(8'd10)) u_htf_host (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat_o), .wb_ack_o(ack_o), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n));

  htf_sensor_model u_htf_sensor_model (
    .scl_i(scl_w), .sda_i(sda_w), .mute_i(mute), .slow_i(slow),
    .scl_dn_o(scl_dn), .sda_dn_o(sda_dn), .viol_o(viol));

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic expect_word(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
    check_count++;
    if ((got & mask) !== (exp & mask)) begin
      n_fail++;
      $display("unexpected value at %0t: got %h expected %h", $time, got & mask, exp & mask);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    r = rdat_o;
    cyc <= 0;
    stb <= 0;
    if (k >= 50) begin
      n_fail++;
      complete_run();
    end
  endtask

  task automatic run_op(input logic [2:0] op, input logic [2:0] cnt);
    logic [31:0] s;
    int k;
    wb(1, `HTF_WB_CTRL, {26'h0, cnt, op}, s);
    k = 0;
    do begin
      repeat (50) @(posedge clk_i);
      wb(0, `HTF_WB_STAT, 32'h0, s);
      k++;
    end while (s[0] !== 1'b0 && k < 200);
    if (k >= 200) begin
      n_fail++;
      complete_run();
    end
  endtask

  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    {rst_i, cyc, stb, we, mute, slow} = 6'b100000;
    {adr, sel, wdat} = '0;
    n_fail = 0;
    check_count = 0;
    nv_adr = '{8'h1e, 8'h1f, 8'h06, 8'h11};
    nv_exp = '{ID_HI, ID_LO, (HUM_WORD & 16'hf3ff) | 16'h0400, (TMP_WORD & 16'hf3ff) | 16'h0800};
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    wb(0, `HTF_WB_STAT, 32'h0, q);
    expect_word(q, 32'h04, 32'h7f);
    wb(0, `HTF_WB_RES, 32'h0, q);
    expect_word(q, 32'h3, 32'h3);
    wb(0, 8'h1c, 32'h0, q);
    expect_word(q, 32'h0, 32'hffffffff);
    $display("test reset values done");
    run_op(3'h2, 3'h2);
    wb(0, `HTF_WB_STAT, 32'h0, q);
    expect_word(q, 32'h04, 32'h1e);
    $display("test early fetch done");
    run_op(3'h3, 3'h0);
    wb(0, `HTF_WB_STAT, 32'h0, q);
    expect_word(q, 32'h20, 32'h23);
    wb(1, `HTF_WB_RES, 32'h1, q);
    wb(1, `HTF_WB_NVADDR, 32'h06, q);
    run_op(3'h7, 3'h0);
    wb(1, `HTF_WB_NVDATA, {16'h0, (TMP_WORD & 16'hf3ff) | 16'h0800}, q);
    wb(1, `HTF_WB_NVADDR, 32'h51, q);
    run_op(3'h6, 3'h0);
    for (int i = 0; i < 4; i++) begin
      wb(1, `HTF_WB_NVADDR, {24'h0, nv_adr[i]}, q);
      run_op(3'h5, 3'h0);
      wb(0, `HTF_WB_NVDATA, 32'h0, q);
      expect_word(q, {16'h0, nv_exp[i]}, 32'hffff);
    end
    wb(0, `HTF_WB_NVADDR, 32'h0, q);
    expect_word(q, 32'h11, 32'hff);
    run_op(3'h4, 3'h0);
    wb(0, `HTF_WB_STAT, 32'h0, q);
    expect_word(q, 32'h00, 32'h23);
    $display("test programming mode done");
    slow <= 1;
    run_op(3'h1, 3'h0);
    slow <= 0;
    run_op(3'h2, 3'h4);
    wb(0, `HTF_WB_STAT, 32'h0, q);
    expect_word(q, 32'h10, 32'h1e);
    wb(0, `HTF_WB_HUM, 32'h0, q);
    expect_word(q, {18'h0, HUM_VAL}, 32'h3fff);
    wb(0, `HTF_WB_TEMP, 32'h0, q);
    expect_word(q, {18'h0, TMP_VAL}, 32'h3fff);
    run_op(3'h2, 3'h3);
    wb(0, `HTF_WB_STAT, 32'h0, q);
    expect_word(q, 32'h04, 32'h1e);
    wb(0, `HTF_WB_TEMP, 32'h0, q);
    expect_word(q, {18'h0, TMP_VAL[13:6], 6'h0}, 32'h3fff);
    wb(0, `HTF_WB_CTRL, 32'h0, q);
    expect_word(q, 32'h1a, 32'h3f);
    $display("test measure and fetch done");
    mute <= 1;
    run_op(3'h1, 3'h0);
    mute <= 0;
    wb(0, `HTF_WB_STAT, 32'h0, q);
    expect_word(q, 32'h06, 32'h0f);
    wb(0, `HTF_WB_HUM, 32'h0, q);
    expect_word(q, {18'h0, HUM_VAL}, 32'h3fff);
    expect_word({31'h0, viol}, 32'h0, 32'h1);
    $display("test refused address done");
    complete_run();
  end
endmodule // test_htf_host

//--- verilog/htf_host.sv
// bus master that drives the sensor over its two open-drain wires, ordered over classic wishbone
// assumes pull-ups on both wires and a single master on the bus
//
// Implementation choice: the Wishbone interface to the registers.
`include "htf_params.svh"
module htf_host #(
  parameter logic [31:0] LOAD_CYC   = `HTF_LOAD_CYC,
  parameter logic [31:0] COMMIT_CYC = `HTF_COMMIT_CYC,
  parameter logic [31:0] MEAS_CYC   = `HTF_MEAS_CYC,
  parameter logic [7:0]  QTR_CYC    = `HTF_QTR_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o
);
  htf_pkg::htf_state_t st_r;
  htf_pkg::htf_op_t    op_r;
  logic [1:0]  seq_r;
  logic [7:0]  q_cnt_r;
  logic [1:0]  qph_r;
  logic        scl_lo_r, sda_lo_r;
  logic [1:0]  scl_sy_r, sda_sy_r;
  logic        rw_r, ack_in_r, abort_r;
  logic [2:0]  nbyte_r, byte_idx_r, fetch_n_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  sh_r;
  logic [7:0]  tx_buf_r [0:2];
  logic [7:0]  rx_buf_r [0:3];
  logic [31:0] wait_cnt_r;
  logic [1:0]  status_r, res_r;
  logic [13:0] hum_r, temp_r;
  logic [15:0] nv_wdata_r, nv_rdata_r;
  logic [7:0]  nv_addr_r;
  logic        nack_err_r, prog_r, ack_r;
  logic [31:0] dat_r;
  // descriptor of the next transfer, from operation and step
  logic        nx_rw, nx_last;
  logic [2:0]  nx_n;
  logic [7:0]  nx_b0, nx_b1, nx_b2, nv_waddr;
  logic [15:0] rmw_word;
  logic [31:0] nx_wait;
  logic        qtick, is_tx, go, wr_en, step_done;

  assign scl_o      = 1'b0;
  assign sda_o      = 1'b0;
  assign scl_oe_n_o = ~scl_lo_r;
  assign sda_oe_n_o = ~sda_lo_r;
  assign wb_ack_o   = ack_r;
  assign wb_dat_o   = dat_r;

  always_ff @(posedge clk_i) begin
    scl_sy_r <= {scl_sy_r[0], scl_i};
    sda_sy_r <= {sda_sy_r[0], sda_i};
  end

  // keep all other bits of the word, replace only the resolution field
  assign rmw_word = {rx_buf_r[1][7:4], res_r, rx_buf_r[1][1:0], rx_buf_r[2]};
  assign nv_waddr = (nv_addr_r == `HTF_NV_TMP_RD) ? `HTF_NV_TMP_WR : `HTF_NV_HUM_WR;

  always_comb begin
    nx_rw   = 1'b0;
    nx_n    = 3'h3;
    nx_b0   = `HTF_CMD_ZERO;
    nx_b1   = `HTF_CMD_ZERO;
    nx_b2   = `HTF_CMD_ZERO;
    nx_wait = 32'h0;
    nx_last = 1'b1;
    case (op_r)
      htf_pkg::OP_MEASURE: begin
        nx_n    = 3'h0;
        nx_wait = MEAS_CYC;
      end
      htf_pkg::OP_FETCH: begin
        nx_rw = 1'b1;
        nx_n  = fetch_n_r;
      end
      htf_pkg::OP_ENTER: begin
        nx_b0   = `HTF_CMD_ENTER;
        nx_wait = LOAD_CYC;
      end
      htf_pkg::OP_EXIT: nx_b0 = `HTF_CMD_EXIT;
      htf_pkg::OP_NVREAD, htf_pkg::OP_RESOLVE: begin
        if (seq_r == 2'h0) begin
          nx_b0   = nv_addr_r;
          nx_wait = LOAD_CYC;
          nx_last = 1'b0;
        end else if (seq_r == 2'h1) begin
          nx_rw   = 1'b1;
          nx_n    = `HTF_NV_RD_BYTES;
          nx_last = (op_r == htf_pkg::OP_NVREAD);
        end else begin
          nx_b0   = nv_waddr;
          nx_b1   = rmw_word[15:8];
          nx_b2   = rmw_word[7:0];
          nx_wait = COMMIT_CYC;
        end
      end
      htf_pkg::OP_NVWRITE: begin
        nx_b0   = nv_addr_r;
        nx_b1   = nv_wdata_r[15:8];
        nx_b2   = nv_wdata_r[7:0];
        nx_wait = COMMIT_CYC;
      end
      default: nx_n = 3'h0;
    endcase
  end

  // hold the quarter counter while a slave stretches the released clock
  assign qtick = (q_cnt_r == QTR_CYC - 8'h1) && !(!scl_lo_r && !scl_sy_r[1]);
  assign is_tx = (byte_idx_r == 3'h0) || !rw_r;
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
  assign go    = wr_en && (wb_adr_i == `HTF_WB_CTRL) && wb_sel_i[0] && (st_r == htf_pkg::ST_IDLE)
               && (wb_dat_i[2:0] != 3'h0);
  assign step_done = ((st_r == htf_pkg::ST_STOP) && qtick && (qph_r == 2'h3) && (nx_wait == 32'h0 || abort_r))
                   || ((st_r == htf_pkg::ST_WAIT) && (wait_cnt_r == 32'h1));

  always_ff @(posedge clk_i) begin
    if (rst_i || st_r == htf_pkg::ST_IDLE || st_r == htf_pkg::ST_WAIT || qtick) begin
      q_cnt_r <= 8'h0;
    end else if (q_cnt_r == QTR_CYC - 8'h1) begin
      q_cnt_r <= q_cnt_r;
    end else begin
      q_cnt_r <= q_cnt_r + 8'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r       <= htf_pkg::ST_IDLE;
      op_r       <= htf_pkg::OP_NONE;
      seq_r      <= 2'h0;
      qph_r      <= 2'h0;
      scl_lo_r   <= 1'b0;
      sda_lo_r   <= 1'b0;
      rw_r       <= 1'b0;
      nbyte_r    <= 3'h0;
      byte_idx_r <= 3'h0;
      bit_cnt_r  <= 4'h0;
      sh_r       <= 8'h0;
      ack_in_r   <= 1'b0;
      abort_r    <= 1'b0;
      wait_cnt_r <= 32'h0;
      for (int i = 0; i < 3; i++) tx_buf_r[i] <= 8'h0;
      for (int i = 0; i < 4; i++) rx_buf_r[i] <= 8'h0;
    end else begin
      case (st_r)
        htf_pkg::ST_IDLE: begin
          if (go) begin
            op_r    <= htf_pkg::htf_op_t'(wb_dat_i[2:0]);
            seq_r   <= 2'h0;
            abort_r <= 1'b0;
            st_r    <= htf_pkg::ST_START;
            qph_r   <= 2'h0;
            for (int i = 0; i < 4; i++) rx_buf_r[i] <= 8'h0;
          end
        end
        htf_pkg::ST_START: begin
          if (qtick) begin
            qph_r <= qph_r + 2'h1;
            if (qph_r == 2'h0) begin
              sda_lo_r <= 1'b1;
            end else if (qph_r == 2'h1) begin
              scl_lo_r    <= 1'b1;
              rw_r        <= nx_rw;
              nbyte_r     <= nx_n;
              tx_buf_r[0] <= nx_b0;
              tx_buf_r[1] <= nx_b1;
              tx_buf_r[2] <= nx_b2;
              sh_r        <= {`HTF_DEV_ADDR, nx_rw};
              byte_idx_r  <= 3'h0;
              bit_cnt_r   <= 4'h0;
              qph_r       <= 2'h0;
              st_r        <= htf_pkg::ST_BIT;
            end
          end
        end
        htf_pkg::ST_BIT: begin
          if (qtick) begin
            qph_r <= qph_r + 2'h1;
            case (qph_r)
              2'h0: begin
                if (bit_cnt_r != 4'h8) begin
                  sda_lo_r <= is_tx && !sh_r[7];
                end else begin
                  sda_lo_r <= !is_tx && (byte_idx_r != nbyte_r);
                end
              end
              2'h1: scl_lo_r <= 1'b0;
              2'h2: begin
                if (bit_cnt_r != 4'h8) begin
                  sh_r <= {sh_r[6:0], sda_sy_r[1]};
                  if (bit_cnt_r == 4'h7 && !is_tx) begin
                    rx_buf_r[2'(byte_idx_r - 3'h1)] <= {sh_r[6:0], sda_sy_r[1]};
                  end
                end else begin
                  ack_in_r <= sda_sy_r[1];
                end
              end
              default: begin
                scl_lo_r <= 1'b1;
                if (bit_cnt_r == 4'h8) begin
                  bit_cnt_r <= 4'h0;
                  if (is_tx && ack_in_r) begin
                    abort_r <= 1'b1;
                    st_r    <= htf_pkg::ST_STOP;
                  end else if (byte_idx_r == nbyte_r) begin
                    st_r <= htf_pkg::ST_STOP;
                  end else begin
                    byte_idx_r <= byte_idx_r + 3'h1;
                    sh_r       <= tx_buf_r[2'(byte_idx_r)];
                  end
                end else begin
                  bit_cnt_r <= bit_cnt_r + 4'h1;
                end
              end
            endcase
          end
        end
        htf_pkg::ST_STOP: begin
          if (qtick) begin
            qph_r <= qph_r + 2'h1;
            if (qph_r == 2'h0) begin
              sda_lo_r <= 1'b1;
            end else if (qph_r == 2'h1) begin
              scl_lo_r <= 1'b0;
            end else if (qph_r == 2'h2) begin
              sda_lo_r <= 1'b0;
            end else if (!abort_r && nx_wait != 32'h0) begin
              wait_cnt_r <= nx_wait;
              st_r       <= htf_pkg::ST_WAIT;
            end
          end
        end
        htf_pkg::ST_WAIT: wait_cnt_r <= wait_cnt_r - 32'h1;
        default: st_r <= htf_pkg::ST_IDLE;
      endcase
      if (step_done) begin
        if (nx_last || abort_r) begin
          st_r <= htf_pkg::ST_IDLE;
        end else begin
          seq_r <= seq_r + 2'h1;
          qph_r <= 2'h0;
          st_r  <= htf_pkg::ST_START;
        end
      end
    end
  end

  // results of the last completed fetch or register read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r   <= `HTF_STAT_STALE;
      hum_r      <= 14'h0;
      temp_r     <= 14'h0;
      nv_rdata_r <= 16'h0;
    end else if (step_done && !abort_r) begin
      if (op_r == htf_pkg::OP_FETCH) begin
        status_r <= rx_buf_r[0][7:6];
        hum_r    <= {rx_buf_r[0][5:0], rx_buf_r[1]};
        temp_r   <= {rx_buf_r[2], rx_buf_r[3][7:2]};
      end else if (seq_r == 2'h1) begin
        nv_rdata_r <= {rx_buf_r[1], rx_buf_r[2]};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_r <= 1'b0;
    end else if (step_done && !abort_r && op_r == htf_pkg::OP_ENTER) begin
      prog_r <= 1'b1;
    end else if (step_done && !abort_r && op_r == htf_pkg::OP_EXIT) begin
      prog_r <= 1'b0;
    end
  end

  // a nack raised by the hardware wins over a clear by a new order
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nack_err_r <= 1'b0;
    end else if (st_r == htf_pkg::ST_BIT && qtick && qph_r == 2'h3 && bit_cnt_r == 4'h8 && is_tx && ack_in_r) begin
      nack_err_r <= 1'b1;
    end else if (go) begin
      nack_err_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fetch_n_r  <= 3'h4;
      nv_wdata_r <= 16'h0;
      nv_addr_r  <= `HTF_NV_HUM_RD;
      res_r      <= `HTF_RES_DEFAULT;
    end else if (wr_en) begin
      if (go) begin
        fetch_n_r <= (wb_dat_i[5:3] < 3'h2) ? 3'h2 : ((wb_dat_i[5:3] > 3'h4) ? 3'h4 : wb_dat_i[5:3]);
      end
      if (wb_adr_i == `HTF_WB_NVDATA) begin
        if (wb_sel_i[0]) nv_wdata_r[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) nv_wdata_r[15:8] <= wb_dat_i[15:8];
      end
      if (wb_adr_i == `HTF_WB_NVADDR && wb_sel_i[0] && st_r == htf_pkg::ST_IDLE) nv_addr_r <= wb_dat_i[7:0];
      if (wb_adr_i == `HTF_WB_RES && wb_sel_i[0] && st_r == htf_pkg::ST_IDLE) res_r <= wb_dat_i[1:0];
    end
  end

  // answer one cycle after the strobe, drop ack the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      if (wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i) begin
        case (wb_adr_i)
          `HTF_WB_CTRL:   dat_r <= {26'h0, fetch_n_r, op_r};
          `HTF_WB_STAT:   dat_r <= {25'h0, st_r == htf_pkg::ST_WAIT, prog_r, status_r == `HTF_STAT_VALID,
                                    status_r, nack_err_r, st_r != htf_pkg::ST_IDLE};
          `HTF_WB_HUM:    dat_r <= {18'h0, hum_r};
          `HTF_WB_TEMP:   dat_r <= {18'h0, temp_r};
          `HTF_WB_NVDATA: dat_r <= {16'h0, nv_rdata_r};
          `HTF_WB_NVADDR: dat_r <= {24'h0, nv_addr_r};
          `HTF_WB_RES:    dat_r <= {30'h0, res_r};
          default:        dat_r <= 32'h0;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_wb_ack_pulse: assert property ((wb_cyc_i && wb_stb_i && !ack_r) |=> ack_r ##1 !ack_r)
    else $error("wishbone ack not a single pulse one cycle after strobe");
  a_dev_address: assert property ((st_r == htf_pkg::ST_START && qtick && qph_r == 2'h1)
    |=> (sh_r[7:1] == `HTF_DEV_ADDR)) else $error("wrong device address loaded");
  a_fetch_dir: assert property ((st_r == htf_pkg::ST_BIT && op_r == htf_pkg::OP_FETCH) |-> rw_r)
    else $error("fetch not issued as a read");
  a_last_nack: assert property ((st_r == htf_pkg::ST_BIT && !is_tx && bit_cnt_r == 4'h8 && byte_idx_r == nbyte_r
    && qph_r == 2'h1) |-> !sda_lo_r) else $error("last read byte not answered with nack");
  a_enter_bytes: assert property ((st_r == htf_pkg::ST_BIT && op_r == htf_pkg::OP_ENTER)
    |-> (tx_buf_r[0] == `HTF_CMD_ENTER && tx_buf_r[1] == 8'h0 && tx_buf_r[2] == 8'h0))
    else $error("entry command bytes wrong");
  a_exit_bytes: assert property ((st_r == htf_pkg::ST_BIT && op_r == htf_pkg::OP_EXIT)
    |-> (tx_buf_r[0] == `HTF_CMD_EXIT && nbyte_r == 3'h3)) else $error("exit command bytes wrong");
  a_meas_wait: assert property (($rose(st_r == htf_pkg::ST_WAIT) && op_r == htf_pkg::OP_MEASURE)
    |-> wait_cnt_r == MEAS_CYC) else $error("measurement wait not loaded");
  a_commit_wait: assert property (($rose(st_r == htf_pkg::ST_WAIT) && (op_r == htf_pkg::OP_NVWRITE
    || seq_r == 2'h2)) |-> wait_cnt_r == COMMIT_CYC) else $error("commit wait not loaded");
  a_hum_pack: assert property (($fell(st_r != htf_pkg::ST_IDLE) && op_r == htf_pkg::OP_FETCH && !abort_r)
    |-> (hum_r == {rx_buf_r[0][5:0], rx_buf_r[1]} && status_r == rx_buf_r[0][7:6]))
    else $error("humidity or status unpacked wrongly");
  a_rmw_word: assert property ((st_r == htf_pkg::ST_BIT && op_r == htf_pkg::OP_RESOLVE && seq_r == 2'h2)
    |-> ({tx_buf_r[1], tx_buf_r[2]} == {rx_buf_r[1][7:4], res_r, rx_buf_r[1][1:0], rx_buf_r[2]}))
    else $error("resolution write word does not keep other bits");
  c_fetch_done: cover property ($fell(st_r != htf_pkg::ST_IDLE) && op_r == htf_pkg::OP_FETCH);
  c_enter_done: cover property (step_done && op_r == htf_pkg::OP_ENTER);
  c_resolve_done: cover property (step_done && op_r == htf_pkg::OP_RESOLVE && seq_r == 2'h2);
  c_nack_abort: cover property ($rose(abort_r));
endmodule // htf_host
